// [core/frrc_pkg.sv]
// constants shared by the reset and retransmit control of the 9-bit buffer
// assumes one clock, synchronous active-low reset, plain register port
package frrc_pkg;

  localparam int          DATA_W         = 9;
  localparam int          DEPTH_DEF      = 16384;
  localparam int          REG_AW         = 8;
  localparam int          REG_DW         = 32;
  localparam int          OFS_W          = 16;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [7:0]  ADDR_STATUS    = 8'h00;
  localparam logic [7:0]  ADDR_INT_EN    = 8'h04;
  localparam logic [7:0]  ADDR_INT_CLR   = 8'h08;
  localparam logic [7:0]  ADDR_CONFIG    = 8'h0c;
  localparam logic [7:0]  ADDR_AE_OFS    = 8'h10;
  localparam logic [7:0]  ADDR_AF_OFS    = 8'h14;
  localparam logic [7:0]  ADDR_LEVEL     = 8'h18;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status bit positions
  localparam int          EV_EMPTY       = 0;
  localparam int          EV_FULL        = 1;
  localparam int          EV_REREAD      = 2;
  localparam int          EV_OVERFLOW    = 3;
  localparam int          EV_UNDERFLOW   = 4;
  localparam int          EV_W           = 5;

  // config register bit positions
  localparam int          CFG_FALL       = 0;
  localparam int          CFG_SERIAL     = 1;

  ////////////////////////////////////////////////////////////////////////////
  // default offsets and timing counts
  localparam logic [15:0] OFS_PARALLEL   = 16'h007f;
  localparam logic [15:0] OFS_SERIAL     = 16'h03ff;
  localparam logic [15:0] OFS_RESET      = 16'h03ff;
  localparam int          FALL_LATENCY   = 3;
  localparam int          REREAD_BLANK   = 3;
  localparam int          CNT_W          = 2;

endpackage

// [core/frrc_top.sv]
// buffer core with full reset, pointer reset and retransmit control
// assumes write and read sides run on CLK and drive pins synchronously
`timescale 1ns/1ps
module frrc_top #(
  parameter int DEPTH = frrc_pkg::DEPTH_DEF
) (
  input  wire logic                        CLK,
  input  wire logic                        NRST,
  input  wire logic                        FULL_RESET_N,
  input  wire logic                        POINTER_RESET_N,
  input  wire logic                        REREAD_REQUEST_N,
  input  wire logic                        LOAD_SELECT_N,
  input  wire logic                        MODE_SELECT_SERIAL_IN,
  input  wire logic                        WRITE_EN_N,
  input  wire logic [frrc_pkg::DATA_W-1:0] WRITE_DATA_IN,
  input  wire logic                        READ_EN_N,
  output logic      [frrc_pkg::DATA_W-1:0] READ_DATA_OUT,
  output logic                             EMPTY_FLAG_N,
  output logic                             FULL_FLAG_N,
  output logic                             ALMOST_EMPTY_N,
  output logic                             ALMOST_FULL_N,
  input  wire logic [frrc_pkg::REG_AW-1:0] REG_ADDR,
  input  wire logic [frrc_pkg::REG_DW-1:0] REG_WDATA,
  input  wire logic                        REG_WR,
  input  wire logic                        REG_RD,
  output logic      [frrc_pkg::REG_DW-1:0] REG_RDATA,
  output logic                             IRQ
);

  localparam int AW = $clog2(DEPTH);
  localparam int REG_DW_T = frrc_pkg::REG_DW;

  ////////////////////////////////////////////////////////////////////////////
  // storage and state

  logic [frrc_pkg::DATA_W-1:0]  mem [DEPTH];
  logic [AW:0]                  wr_ptr_reg;
  logic [AW:0]                  rd_ptr_reg;
  logic [AW:0]                  level;
  logic                         fall_reg;
  logic                         serial_reg;
  logic [frrc_pkg::OFS_W-1:0]   ae_ofs_reg;
  logic [frrc_pkg::OFS_W-1:0]   af_ofs_reg;
  logic                         out_valid_reg;
  logic [frrc_pkg::CNT_W-1:0]   fall_cnt_reg;
  logic [frrc_pkg::CNT_W-1:0]   blank_cnt_reg;
  logic [frrc_pkg::EV_W-1:0]    status_reg;
  logic [frrc_pkg::EV_W-1:0]    int_en_reg;
  logic [frrc_pkg::EV_W-1:0]    events;
  logic                         any_reset;
  logic                         reread;
  logic                         blanking;
  logic                         is_empty;
  logic                         is_full;
  logic                         wr_do;
  logic                         std_rd;
  logic                         fall_load;
  logic                         fall_pop;
  logic                         rd_do;
  logic                         empty_d_reg;
  logic                         full_d_reg;
  logic                         empty_next;
  logic                         ae_next;
  logic                         af_next;
  logic [AW:0]                  depth_w;
  logic [AW:0]                  ae_thr;
  logic [AW:0]                  af_thr;

  ////////////////////////////////////////////////////////////////////////////
  // request decode

  assign any_reset = !FULL_RESET_N || !POINTER_RESET_N;
  assign reread    = !REREAD_REQUEST_N && !any_reset;
  assign level     = wr_ptr_reg - rd_ptr_reg;
  assign depth_w   = (AW+1)'(DEPTH);
  assign is_empty  = (level == '0);
  assign is_full   = (level == depth_w);
  assign blanking  = (blank_cnt_reg != '0);

  // writes are refused while full so stored words are never overwritten
  assign wr_do     = !WRITE_EN_N && !is_full && !any_reset;

  // standard mode: every word needs an explicit read
  assign std_rd    = !fall_reg && !READ_EN_N && !is_empty && !blanking && !reread;

  // fall-through: first word loads itself after the latency count
  assign fall_load = fall_reg && !out_valid_reg && !is_empty && !blanking && !reread
                     && (fall_cnt_reg == frrc_pkg::CNT_W'(frrc_pkg::FALL_LATENCY - 1));
  assign fall_pop  = fall_reg && out_valid_reg && !READ_EN_N && !blanking && !reread;
  assign rd_do     = std_rd || fall_load || (fall_pop && !is_empty) ;

  ////////////////////////////////////////////////////////////////////////////
  // memory array, no reset so it maps onto block ram

  always_ff @(posedge CLK)
  begin
    if (wr_do)
    begin
      mem[wr_ptr_reg[AW-1:0]] <= WRITE_DATA_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // write pointer

  always_ff @(posedge CLK)
  begin
    if (!NRST || any_reset)
    begin
      wr_ptr_reg <= '0;
    end
    else if (wr_do)
    begin
      wr_ptr_reg <= wr_ptr_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read pointer

  always_ff @(posedge CLK)
  begin
    if (!NRST || any_reset)
    begin
      rd_ptr_reg <= '0;
    end
    else if (reread)
    begin
      rd_ptr_reg <= '0;
    end
    else if (rd_do)
    begin
      rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output data register

  always_ff @(posedge CLK)
  begin
    if (!NRST || any_reset)
    begin
      READ_DATA_OUT <= '0;
    end
    else if (rd_do)
    begin
      READ_DATA_OUT <= mem[rd_ptr_reg[AW-1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fall-through word holding and latency count

  always_ff @(posedge CLK)
  begin
    if (!NRST || any_reset || reread)
    begin
      out_valid_reg <= 1'b0;
      fall_cnt_reg  <= '0;
    end
    else if (fall_load)
    begin
      out_valid_reg <= 1'b1;
      fall_cnt_reg  <= '0;
    end
    else if (fall_pop && is_empty)
    begin
      out_valid_reg <= 1'b0;
    end
    else if (fall_reg && !out_valid_reg && !is_empty && !blanking)
    begin
      fall_cnt_reg <= fall_cnt_reg + 1'b1;
    end
    else
    begin
      fall_cnt_reg <= '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // retransmit blanking window

  always_ff @(posedge CLK)
  begin
    if (!NRST || any_reset)
    begin
      blank_cnt_reg <= '0;
    end
    else if (reread)
    begin
      blank_cnt_reg <= frrc_pkg::CNT_W'(frrc_pkg::REREAD_BLANK);
    end
    else if (blanking)
    begin
      blank_cnt_reg <= blank_cnt_reg - 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration latched only during full reset

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      fall_reg   <= 1'b0;
      serial_reg <= 1'b1;
    end
    else if (!FULL_RESET_N)
    begin
      fall_reg   <= MODE_SELECT_SERIAL_IN;
      serial_reg <= LOAD_SELECT_N;
    end
  end

  // offsets survive pointer reset and retransmit; software may reprogram
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      ae_ofs_reg <= frrc_pkg::OFS_RESET;
      af_ofs_reg <= frrc_pkg::OFS_RESET;
    end
    else if (!FULL_RESET_N)
    begin
      ae_ofs_reg <= LOAD_SELECT_N ? frrc_pkg::OFS_SERIAL : frrc_pkg::OFS_PARALLEL;
      af_ofs_reg <= LOAD_SELECT_N ? frrc_pkg::OFS_SERIAL : frrc_pkg::OFS_PARALLEL;
    end
    else if (REG_WR && REG_ADDR == frrc_pkg::ADDR_AE_OFS)
    begin
      ae_ofs_reg <= REG_WDATA[frrc_pkg::OFS_W-1:0];
    end
    else if (REG_WR && REG_ADDR == frrc_pkg::ADDR_AF_OFS)
    begin
      af_ofs_reg <= REG_WDATA[frrc_pkg::OFS_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flags, registered so every output comes from a flip-flop

  // offsets wider than the count saturate rather than wrap
  assign ae_thr = (int'(ae_ofs_reg) > DEPTH) ? depth_w : (AW+1)'(ae_ofs_reg);
  assign af_thr = (int'(af_ofs_reg) > DEPTH) ? '0 : depth_w - (AW+1)'(af_ofs_reg);

  always_comb
  begin
    if (fall_reg)
    begin
      empty_next = out_valid_reg && !blanking && !reread;
    end
    else
    begin
      empty_next = !is_empty && !blanking && !reread;
    end
    ae_next = (level > ae_thr);
    af_next = (level < af_thr);
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST || any_reset)
    begin
      EMPTY_FLAG_N   <= !fall_reg ? 1'b0 : 1'b1;
      FULL_FLAG_N    <= 1'b1;
      ALMOST_EMPTY_N <= 1'b0;
      ALMOST_FULL_N  <= 1'b1;
    end
    else
    begin
      EMPTY_FLAG_N   <= fall_reg ? !empty_next : empty_next;
      FULL_FLAG_N    <= !is_full;
      ALMOST_EMPTY_N <= ae_next;
      ALMOST_FULL_N  <= af_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt events and sticky status

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      empty_d_reg <= 1'b1;
      full_d_reg  <= 1'b0;
    end
    else
    begin
      empty_d_reg <= is_empty;
      full_d_reg  <= is_full;
    end
  end

  always_comb
  begin
    events                         = '0;
    events[frrc_pkg::EV_EMPTY]     = is_empty && !empty_d_reg;
    events[frrc_pkg::EV_FULL]      = is_full && !full_d_reg;
    events[frrc_pkg::EV_REREAD]    = reread;
    events[frrc_pkg::EV_OVERFLOW]  = !WRITE_EN_N && is_full && !any_reset;
    events[frrc_pkg::EV_UNDERFLOW] = !READ_EN_N && !fall_reg && is_empty && !any_reset;
  end

  // a new event beats a clear landing in the same cycle
  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      status_reg <= '0;
    end
    else if (REG_WR && REG_ADDR == frrc_pkg::ADDR_INT_CLR)
    begin
      status_reg <= (status_reg & ~REG_WDATA[frrc_pkg::EV_W-1:0]) | events;
    end
    else
    begin
      status_reg <= status_reg | events;
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      int_en_reg <= '0;
    end
    else if (REG_WR && REG_ADDR == frrc_pkg::ADDR_INT_EN)
    begin
      int_en_reg <= REG_WDATA[frrc_pkg::EV_W-1:0];
    end
  end

  always_ff @(posedge CLK)
  begin
    if (!NRST)
    begin
      IRQ <= 1'b0;
    end
    else
    begin
      IRQ <= |(status_reg & int_en_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port: data stands in each cycle after one with REG_RD high, zero otherwise

  always_ff @(posedge CLK)
  begin
    if (!NRST || !REG_RD)
    begin
      REG_RDATA <= '0;
    end
    else
    begin
      unique case (REG_ADDR)
        frrc_pkg::ADDR_STATUS: REG_RDATA <= REG_DW_T'(status_reg);
        frrc_pkg::ADDR_INT_EN: REG_RDATA <= REG_DW_T'(int_en_reg);
        frrc_pkg::ADDR_CONFIG: REG_RDATA <= REG_DW_T'({serial_reg, fall_reg});
        frrc_pkg::ADDR_AE_OFS: REG_RDATA <= REG_DW_T'(ae_ofs_reg);
        frrc_pkg::ADDR_AF_OFS: REG_RDATA <= REG_DW_T'(af_ofs_reg);
        frrc_pkg::ADDR_LEVEL:  REG_RDATA <= REG_DW_T'(level);
        default:               REG_RDATA <= '0;
      endcase
    end
  end

endmodule

// [sim/frrc_partner.sv]
// write-side and read-side controller driving the data pins
// assumes the core samples strobes on the rising clock edge
`timescale 1ns/1ps
module frrc_partner (
  input  wire logic                        clk,
  output logic                             wen_n,
  output logic      [frrc_pkg::DATA_W-1:0] wdata,
  output logic                             ren_n
);
  initial
  begin
    wen_n = 1'b1;
    ren_n = 1'b1;
    wdata = '0;
  end
  task automatic put(input logic [frrc_pkg::DATA_W-1:0] d);
    @(posedge clk);
    wen_n <= 1'b0;
    wdata <= d;
    @(posedge clk);
    wen_n <= 1'b1;
    wdata <= ~d; // released bus must not show a stale word
  endtask
  task automatic get();
    @(posedge clk);
    ren_n <= 1'b0;
    @(posedge clk);
    ren_n <= 1'b1;
  endtask
endmodule

// [sim/frrc_top_properties.sv]
// checker for reset and retransmit behaviour at the core pins
// assumes one clock domain, bound onto frrc_top
`timescale 1ns/1ps
module frrc_top_properties (
  input wire logic                        CLK,
  input wire logic                        NRST,
  input wire logic                        FULL_RESET_N,
  input wire logic                        POINTER_RESET_N,
  input wire logic                        REREAD_REQUEST_N,
  input wire logic                        MODE_SELECT_SERIAL_IN,
  input wire logic                        READ_EN_N,
  input wire logic [frrc_pkg::DATA_W-1:0] READ_DATA_OUT,
  input wire logic                        EMPTY_FLAG_N,
  input wire logic                        FULL_FLAG_N,
  input wire logic                        ALMOST_EMPTY_N
);
  logic fall_reg;
  logic quiet;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  ////////////////////////////////////////////////////////////////////////////
  // own copy of the timing mode; only a full reset may move it
  always_ff @(posedge CLK)
  begin
    if (!NRST) fall_reg <= 1'b0;
    else if (!FULL_RESET_N) fall_reg <= MODE_SELECT_SERIAL_IN;
  end
  assign quiet = FULL_RESET_N && POINTER_RESET_N && REREAD_REQUEST_N;
  sequence s_req;
    !REREAD_REQUEST_N && FULL_RESET_N && POINTER_RESET_N;
  endsequence
  sequence s_blank_std;
    !EMPTY_FLAG_N [*3];
  endsequence
  sequence s_blank_ff;
    EMPTY_FLAG_N [*3];
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  a_blank_std: assert property (s_req ##0 !fall_reg |=> s_blank_std)
    else $error("empty flag not held low after reread");
  a_blank_ff: assert property (s_req ##0 fall_reg |=> s_blank_ff)
    else $error("output ready not held high after reread");
  a_mode_std: assert property
    ((!FULL_RESET_N && !MODE_SELECT_SERIAL_IN) [*2] |=> !EMPTY_FLAG_N)
    else $error("standard mode not latched");
  a_mode_ff: assert property
    ((!FULL_RESET_N && MODE_SELECT_SERIAL_IN) [*2] |=> EMPTY_FLAG_N)
    else $error("fall-through mode not latched");
  a_ptr_clear: assert property (!POINTER_RESET_N |=>
    READ_DATA_OUT == '0 && FULL_FLAG_N && !ALMOST_EMPTY_N)
    else $error("pointer reset left data or flags");
  a_ptr_keep: assert property
    (!POINTER_RESET_N && FULL_RESET_N |=> EMPTY_FLAG_N == fall_reg)
    else $error("pointer reset changed timing mode");
  a_full_clear: assert property
    (!FULL_RESET_N |=> READ_DATA_OUT == '0 && FULL_FLAG_N)
    else $error("full reset left data or flags");
  a_std_hold: assert property
    (!fall_reg && READ_EN_N && quiet |=> $stable(READ_DATA_OUT))
    else $error("output moved without a read");
  a_ff_hold: assert property
    (fall_reg && !EMPTY_FLAG_N && READ_EN_N && quiet |=> $stable(READ_DATA_OUT))
    else $error("valid word replaced without a read");
endmodule
bind frrc_top frrc_top_properties i_frrc_top_properties (.CLK(CLK), .NRST(NRST),
  .FULL_RESET_N(FULL_RESET_N), .POINTER_RESET_N(POINTER_RESET_N),
  .REREAD_REQUEST_N(REREAD_REQUEST_N), .MODE_SELECT_SERIAL_IN(MODE_SELECT_SERIAL_IN),
  .READ_EN_N(READ_EN_N), .READ_DATA_OUT(READ_DATA_OUT), .EMPTY_FLAG_N(EMPTY_FLAG_N),
  .FULL_FLAG_N(FULL_FLAG_N), .ALMOST_EMPTY_N(ALMOST_EMPTY_N));

// [sim/tb_fifo_reset_retransmit_ctrl.sv]
// self-checking bench for reset and retransmit control
// assumes frrc_top with depth 16 and the partner on the data pins
`timescale 1ns/1ps
module tb_fifo_reset_retransmit_ctrl;
  logic                        clk, nrst, full_n, ptr_n, rr_n, ld_n, mode;
  logic                        wen_n, ren_n, ef_n, ff_n, ae_n, af_n, rwr, rrd, irq;
  logic [frrc_pkg::DATA_W-1:0] wdata, rdata;
  logic [frrc_pkg::DATA_W-1:0] q[$];
  logic [7:0]                  raddr;
  logic [31:0]                 rwdata, rrdata;
  int                          rp, seed, mismatches, n_checks;
  frrc_top #(.DEPTH(16)) i_frrc_top (.CLK(clk), .NRST(nrst), .FULL_RESET_N(full_n),
    .POINTER_RESET_N(ptr_n), .REREAD_REQUEST_N(rr_n), .LOAD_SELECT_N(ld_n),
    .MODE_SELECT_SERIAL_IN(mode), .WRITE_EN_N(wen_n), .WRITE_DATA_IN(wdata),
    .READ_EN_N(ren_n), .READ_DATA_OUT(rdata), .EMPTY_FLAG_N(ef_n), .FULL_FLAG_N(ff_n),
    .ALMOST_EMPTY_N(ae_n), .ALMOST_FULL_N(af_n), .REG_ADDR(raddr), .REG_WDATA(rwdata),
    .REG_WR(rwr), .REG_RD(rrd), .REG_RDATA(rrdata), .IRQ(irq));
  frrc_partner i_frrc_partner (.clk(clk), .wen_n(wen_n), .wdata(wdata), .ren_n(ren_n));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (mismatches == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk_r(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t reg or flag %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_d(input logic [8:0] g, input logic [8:0] e);
    n_checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("BAD %0t data %h want %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rwr <= 1'b1;
    raddr <= a;
    rwdata <= d;
    @(posedge clk);
    rwr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    rrd <= 1'b1;
    raddr <= a;
    @(posedge clk);
    rrd <= 1'b0;
    #1 chk_r(rrdata, e);
  endtask
  // ld and md stay on the pins; both are only sampled under full reset
  task automatic rst_full(input logic ld, input logic md);
    @(posedge clk);
    full_n <= 1'b0;
    ld_n <= ld;
    mode <= md;
    cyc(2);
    full_n <= 1'b1;
    cyc(2);
    q.delete();
    rp = 0;
  endtask
  task automatic pulse(input int rr);
    @(posedge clk);
    if (rr != 0) rr_n <= 1'b0;
    else ptr_n <= 1'b0;
    @(posedge clk);
    rr_n <= 1'b1;
    ptr_n <= 1'b1;
  endtask
  task automatic put_n(input int n);
    logic [8:0] d;
    repeat (n)
    begin
      d = 9'($random(seed));
      q.push_back(d);
      i_frrc_partner.put(d);
    end
    cyc(3);
  endtask
  task automatic get_chk();
    i_frrc_partner.get();
    #1 chk_d(rdata, q[rp]);
    rp++;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #250000 mismatches++;
    end_sim();
  end
  initial
  begin
    {nrst, ptr_n, rr_n, ld_n, mode, rwr, rrd} = 7'h38;
    full_n = 1'b1;
    raddr = 8'h00;
    rwdata = 32'h0;
    seed = 64;
    cyc(4);
    nrst <= 1'b1;
    rst_full(1'b0, 1'b0);
    reg_rd(frrc_pkg::ADDR_CONFIG, 32'h0);
    reg_rd(frrc_pkg::ADDR_AE_OFS, 32'h7f);
    put_n(4);
    reg_rd(frrc_pkg::ADDR_LEVEL, 32'h4);
    chk_r({ff_n, ae_n, af_n}, 32'h4);
    repeat (2) get_chk();
    reg_wr(frrc_pkg::ADDR_INT_EN, 32'h4);
    pulse(1);
    cyc(1);
    #1 chk_r(ef_n, 1'b0);
    rp = 0;
    cyc(4);
    reg_rd(frrc_pkg::ADDR_LEVEL, 32'h4);
    chk_r(irq, 1'b1);
    reg_wr(frrc_pkg::ADDR_INT_CLR, 32'h4);
    cyc(2);
    #1 chk_r(irq, 1'b0);
    repeat (4) get_chk();
    reg_rd(8'h20, 32'h0);
    put_n(16);
    #1 chk_r(ff_n, 1'b0);
    reg_rd(frrc_pkg::ADDR_STATUS, 32'h3);
    reg_wr(frrc_pkg::ADDR_AE_OFS, 32'h5);
    cyc(1);
    #1 chk_r(ae_n, 1'b1);
    pulse(0);
    #1 chk_d(rdata, 9'h000);
    chk_r(ff_n, 1'b1);
    reg_rd(frrc_pkg::ADDR_LEVEL, 32'h0);
    reg_rd(frrc_pkg::ADDR_CONFIG, 32'h0);
    reg_rd(frrc_pkg::ADDR_AE_OFS, 32'h5);
    rst_full(1'b1, 1'b1);
    reg_rd(frrc_pkg::ADDR_CONFIG, 32'h3);
    reg_rd(frrc_pkg::ADDR_AE_OFS, 32'h3ff);
    reg_rd(frrc_pkg::ADDR_LEVEL, 32'h0);
    q.push_back(9'($random(seed)));
    i_frrc_partner.put(q[0]);
    cyc(2);
    #1 chk_d(rdata, 9'h000);
    cyc(1);
    #1 chk_d(rdata, q[0]);
    chk_r(ef_n, 1'b1);
    cyc(1);
    #1 chk_r(ef_n, 1'b0);
    put_n(1);
    cyc(3);
    #1 chk_d(rdata, q[0]);
    pulse(1);
    cyc(1);
    #1 chk_r(ef_n, 1'b1);
    cyc(8);
    #1 chk_d(rdata, q[0]);
    i_frrc_partner.get();
    #1 chk_d(rdata, q[1]);
    end_sim();
  end
endmodule
